/* File: verilog/fram_consts.svh */
// constants for the two-wire byte memory slave
// assumes inclusion by both the package and the design file
`ifndef FRAM_CONSTS_SVH
`define FRAM_CONSTS_SVH
`define MEM_DEPTH      16384
`define ADDR_BITS      14
// device-type code of the address byte: value is arbitrary
`define TYPE_CODE      4'h6
// identification bytes: values are arbitrary
`define ID_BYTE0       8'h5a
`define ID_BYTE1       8'h3c
`define ID_BYTE2       8'h01
`define FIFO_DEPTH     4
`define BIT_LAST       3'h7
`endif

/* File: verilog/fram_pkg.sv */
// types shared by the two-wire byte memory slave
// assumes the constants header is on the include path
`default_nettype none
`include "fram_consts.svh"
package fram_pkg;
  typedef enum logic [2:0] {IDLE, DEVADDR, ADDRHI, ADDRLO, WRDATA, RDDATA, IGNORE} phase_type;
  typedef struct packed {
    logic [`ADDR_BITS-1:0] addr;
    logic [7:0]            data;
  } write_type;
endpackage : fram_pkg
`default_nettype wire

/* File: verilog/fram_two_wire_slave.sv */
// two-wire slave front end and byte array, with a write fifo in front of the array
// assumes scl and sda arrive asynchronously and the clock is far faster than scl
`timescale 1ns/1ps
`default_nettype none
`include "fram_consts.svh"

module write_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clocking
  input  wire logic             clock,
  input  wire logic             reset,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    head;
  logic [PW-1:0]    tail;
  logic [PW:0]      count;
  logic             push;
  logic             pop;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
  end
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = count != (PW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData  = store[tail];
  always_ff @(posedge clock) begin
    if (push) store[head] <= inData;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else begin
      if (push) head <= head + 1'b1;
      if (pop) tail <= tail + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : write_fifo

// Notes on behaviour
// - array of 16,384 bytes reached over the two-wire bus.
// - each received byte goes to the array right after its transfer.
// - a new transaction is accepted straight after a write, no polling.
// - answer only when address select bits equal the select pins.
// - unconnected select pins read as zero (pull-down outside this logic).
// - output changes after scl falls; input sampled when scl rises.
// - write-protect high blocks all array writes; low allows them.
// - unconnected write-protect reads low, writes enabled.
// - a read-only identification value is held.
// - sda is only pulled low or released.
// - works at 100 kHz, 400 kHz and up to 3.4 MHz scl.
// - first byte: type code, three select bits, read flag in bit 0.
// - write sends two address bytes; upper two bits ignored.
// - address increments after every data byte, wrapping to zero.
// - read sends next byte on master ack, ends on no-ack.
module fram_two_wire_slave #(
  parameter int ADDR_BITS = `ADDR_BITS
) (
  // clocking
  input  wire logic       clock,
  input  wire logic       reset,
  // bus pins
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // straps
  input  wire logic [2:0] deviceSelectPins,
  input  wire logic       writeProtect,
  // identification, arbitrary values
  output logic [23:0]     deviceId
);
  initial begin
    if (ADDR_BITS != `ADDR_BITS) $error("array width fixed at 14 address bits");
  end
  // two-flop synchronisers; scl at 3.4 MHz gives about 29 clocks per period
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] selSync [3];
  logic [1:0] wpSync;
  logic       sclLast;
  logic       sdaLast;
  always_ff @(posedge clock) begin
    if (reset) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      // straps idle low like their pad pull-downs, so no false protect after reset
      wpSync  <= 2'h0;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
      for (int i = 0; i < 3; i++) selSync[i] <= 2'h0;
    end else begin
      sclSync <= {sclSync[0], scl};
      sdaSync <= {sdaSync[0], sdaIn};
      wpSync  <= {wpSync[0], writeProtect};
      for (int i = 0; i < 3; i++) selSync[i] <= {selSync[i][0], deviceSelectPins[i]};
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end
  logic [2:0] selNow;
  assign selNow = {selSync[2][1], selSync[1][1], selSync[0][1]};
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  assign sclRise   = sclSync[1] && !sclLast;
  assign sclFall   = !sclSync[1] && sclLast;
  assign startSeen = sclSync[1] && sclLast && sdaLast && !sdaSync[1];
  assign stopSeen  = sclSync[1] && sclLast && !sdaLast && sdaSync[1];

  logic [7:0]           mem [`MEM_DEPTH];
  fram_pkg::phase_type  phase;
  logic [7:0]           shift;
  logic [2:0]           bitCount;
  logic                 ackPhase;
  logic                 ackDrive;
  logic [ADDR_BITS-1:0] addr;
  logic [5:0]           addrHigh;
  logic [7:0]           txByte;
  logic                 fifoIn;
  fram_pkg::write_type  fifoData;
  logic                 fifoReady;
  logic                 drainValid;
  fram_pkg::write_type  drainData;
  logic [7:0]           rxByte;
  logic                 byteDone;
  logic                 readAckDue;
  assign rxByte   = {shift[6:0], sdaSync[1]};
  assign byteDone = sclRise && !ackPhase && bitCount == `BIT_LAST;

  // byte framing: eight rising edges then an acknowledge slot
  always_ff @(posedge clock) begin
    if (reset || startSeen || stopSeen) begin
      bitCount <= 3'h0;
      ackPhase <= 1'b0;
      shift    <= 8'h00;
    end else if (sclRise) begin
      if (ackPhase) begin
        ackPhase <= 1'b0;
      end else begin
        shift    <= rxByte;
        bitCount <= bitCount + 3'h1;
        ackPhase <= bitCount == `BIT_LAST;
      end
    end
  end

  // phase sequencing; start or stop aborts anything in progress
  always_ff @(posedge clock) begin
    if (reset || stopSeen) begin
      phase <= fram_pkg::IDLE;
    end else if (startSeen) begin
      phase <= fram_pkg::DEVADDR;
    end else if (byteDone) begin
      unique case (phase)
        fram_pkg::DEVADDR: begin
          if (rxByte[7:4] == `TYPE_CODE && rxByte[3:1] == selNow) begin
            phase <= rxByte[0] ? fram_pkg::RDDATA : fram_pkg::ADDRHI;
          end else begin
            phase <= fram_pkg::IGNORE;
          end
        end
        fram_pkg::ADDRHI: phase <= fram_pkg::ADDRLO;
        fram_pkg::ADDRLO: phase <= fram_pkg::WRDATA;
        fram_pkg::IDLE, fram_pkg::WRDATA, fram_pkg::RDDATA, fram_pkg::IGNORE: phase <= phase;
      endcase
    end else if (phase == fram_pkg::RDDATA && ackPhase && sclRise && sdaSync[1]) begin
      phase <= fram_pkg::IGNORE;
    end
  end

  // a matched read address byte is acked although the phase already says read;
  // data-byte ack slots in a read belong to the master, so phase alone cannot tell
  always_ff @(posedge clock) begin
    if (reset || startSeen || stopSeen) begin
      readAckDue <= 1'b0;
    end else if (byteDone && phase == fram_pkg::DEVADDR) begin
      readAckDue <= rxByte[7:4] == `TYPE_CODE && rxByte[3:1] == selNow && rxByte[0];
    end else if (sclRise && ackPhase) begin
      readAckDue <= 1'b0;
    end
  end

  // address latch; top two bits of the high byte dropped, wrap by width
  always_ff @(posedge clock) begin
    if (reset) begin
      addr     <= '0;
      addrHigh <= 6'h00;
    end else if (byteDone && phase == fram_pkg::ADDRHI) begin
      addrHigh <= rxByte[5:0];
    end else if (byteDone && phase == fram_pkg::ADDRLO) begin
      addr <= {addrHigh, rxByte};
    end else if (byteDone && (phase == fram_pkg::WRDATA || phase == fram_pkg::RDDATA)) begin
      addr <= addr + 1'b1;
    end
  end

  // write request; protected writes are acked but not queued
  always_ff @(posedge clock) begin
    if (reset) begin
      fifoIn   <= 1'b0;
      fifoData <= '0;
    end else begin
      fifoIn        <= byteDone && phase == fram_pkg::WRDATA && !wpSync[1];
      fifoData.addr <= addr;
      fifoData.data <= rxByte;
    end
  end

  write_fifo #(.WIDTH($bits(fram_pkg::write_type)), .DEPTH(`FIFO_DEPTH)) wrQueue (
    .clock    (clock),
    .reset    (reset),
    .inValid  (fifoIn),
    .inReady  (fifoReady),
    .inData   (fifoData),
    .outValid (drainValid),
    .outReady (1'b1),
    .outData  (drainData)
  );

  // array drains one entry per clock, so the queue never backs up onto the bus
  always_ff @(posedge clock) begin
    if (drainValid) mem[drainData.addr] <= drainData.data;
  end

  // transmit byte; loaded at the read ack, bypassing any write still queued
  always_ff @(posedge clock) begin
    if (reset) begin
      txByte <= 8'h00;
    end else if (sclFall && bitCount == 3'h0 && !ackPhase) begin
      txByte <= mem[addr];
    end else if (sclFall && !ackPhase) begin
      txByte <= {txByte[6:0], 1'b1};
    end
  end

  // sda drive, changed after scl falls and released at start or stop; open drain pulls low only
  always_ff @(posedge clock) begin
    if (reset || startSeen || stopSeen) begin
      ackDrive <= 1'b0;
    end else if (sclFall) begin
      if (ackPhase) begin
        ackDrive <= readAckDue ||
                    (phase != fram_pkg::IDLE && phase != fram_pkg::IGNORE && phase != fram_pkg::RDDATA);
      end else if (phase == fram_pkg::RDDATA) begin
        ackDrive <= bitCount == 3'h0 ? !mem[addr][7] : !txByte[6];
      end else begin
        ackDrive <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      sdaOut   <= 1'b0;
      sdaOe    <= 1'b0;
      deviceId <= 24'h000000;
    end else begin
      sdaOut   <= 1'b0;
      sdaOe    <= ackDrive;
      deviceId <= {`ID_BYTE0, `ID_BYTE1, `ID_BYTE2};
    end
  end

  low_only_a: assert property (@(posedge clock) disable iff (reset) sdaOe |-> !sdaOut)
    else $error("sda driven high");
  sequence ackSlotFall_s;
    sclFall && ackPhase && phase == fram_pkg::WRDATA;
  endsequence
  write_ack_a: assert property (@(posedge clock) disable iff (reset)
    ackSlotFall_s ##1 (!startSeen && !stopSeen) |-> ##1 sdaOe)
    else $error("write byte not acked");
  protect_block_a: assert property (@(posedge clock) disable iff (reset) wpSync[1] |-> ##1 !fifoIn)
    else $error("write queued while protected");
  commit_fast_a: assert property (@(posedge clock) disable iff (reset) fifoIn |-> ##[1:2] drainValid)
    else $error("write not drained");
  addr_step_a: assert property (@(posedge clock) disable iff (reset)
    byteDone && phase == fram_pkg::WRDATA |=> addr == $past(addr) + 1'b1)
    else $error("address did not step");
  stop_idle_a: assert property (@(posedge clock) disable iff (reset) stopSeen |=> phase == fram_pkg::IDLE)
    else $error("stop did not idle");
  select_miss_a: assert property (@(posedge clock) disable iff (reset)
    byteDone && phase == fram_pkg::DEVADDR && rxByte[3:1] != selNow |=> phase == fram_pkg::IGNORE)
    else $error("answered foreign select");
  nack_end_a: assert property (@(posedge clock) disable iff (reset)
    phase == fram_pkg::RDDATA && ackPhase && sclRise && sdaSync[1] && !startSeen && !stopSeen
    |=> phase == fram_pkg::IGNORE)
    else $error("read kept going after nack");
  edge_only_a: assert property (@(posedge clock) disable iff (reset)
    $changed(ackDrive) |-> $past(sclFall) || $past(startSeen) || $past(stopSeen))
    else $error("drive changed off falling edge");
  sequence readAckFall_s;
    sclFall && ackPhase && phase == fram_pkg::RDDATA && readAckDue;
  endsequence
  read_ack_a: assert property (@(posedge clock) disable iff (reset)
    readAckFall_s ##1 (!startSeen && !stopSeen) |-> ##1 sdaOe)
    else $error("read address not acked");
  queue_room_a: assert property (@(posedge clock) disable iff (reset) fifoIn |-> fifoReady)
    else $error("write queue overflow");
endmodule : fram_two_wire_slave
`default_nettype wire

/* File: dv/two_wire_master.sv */
// two-wire bus master model: drives scl and its own pull on the data line
// assumes the bench resolves the shared line and feeds it back on line
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
  // clocking
  input  wire logic clock,
  // bus
  output logic      scl,
  output logic      sdaDrive,
  input  wire logic line
);
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end
  // 8 clocks a half period gives the 160 ns link period; scl stands high between frames
  task automatic half();
    repeat (8) @(negedge clock);
  endtask : half
  // also used as a repeated start from scl low
  task automatic start();
    sdaDrive = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaDrive = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sdaDrive = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaDrive = 1'b1;
    half();
  endtask : stop
  // data changes only while scl is low, line read late in the high phase
  task automatic xfer(input logic b, output logic r);
    sdaDrive = b;
    half();
    scl = 1'b1;
    half();
    r = line;
    scl = 1'b0;
  endtask : xfer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(last, r);
  endtask : rbyte
endmodule : two_wire_master
`default_nettype wire

/* File: dv/tb_fram_two_wire_slave.sv */
// self-checking bench for the two-wire byte memory slave
// assumes the master model file and the constants header are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "fram_consts.svh"
module tb_fram_two_wire_slave;
  logic        clock;
  logic        reset;
  logic        scl;
  logic        sdaDrive;
  logic        sdaOut;
  logic        sdaOe;
  logic        writeProtect;
  logic [2:0]  sel;
  logic [23:0] deviceId;
  logic [3:0]  hiCount = 4'h0;
  logic        lastOe = 1'b0;
  wire logic   line = sdaDrive & (sdaOe ? sdaOut : 1'b1);
  int          n_errors, n_compared, cycles;
  fram_two_wire_slave DUT (.clock(clock), .reset(reset), .scl(scl), .sdaIn(line), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .deviceSelectPins(sel), .writeProtect(writeProtect), .deviceId(deviceId));
  two_wire_master m (.clock(clock), .scl(scl), .sdaDrive(sdaDrive), .line(line));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end
  // the data line must hold still once scl has been high a while
  always @(posedge clock) begin
    if (hiCount > 4'h4 && sdaOe !== lastOe) begin
      n_errors++;
      $display("[FAIL] t=%0t oe %h -> %h with scl high", $time, lastOe, sdaOe);
    end
    hiCount <= scl ? hiCount + {3'h0, hiCount != 4'hf} : 4'h0;
    lastOe <= sdaOe;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic open_at(input logic [2:0] s, input logic [15:0] a);
    logic k;
    m.start();
    m.wbyte({`TYPE_CODE, s, 1'b0}, k);
    check(k, 1);
    m.wbyte(a[15:8], k);
    check(k, 1);
    m.wbyte(a[7:0], k);
    check(k, 1);
  endtask : open_at
  task automatic put(input logic [7:0] d);
    logic k;
    m.wbyte(d, k);
    check(k, 1);
  endtask : put
  // two bytes from the current address, acked then not acked
  task automatic rd2(input logic [2:0] s, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d;
    logic       k;
    m.start();
    m.wbyte({`TYPE_CODE, s, 1'b1}, k);
    check(k, 1);
    m.rbyte(1'b0, d);
    check(d, e0);
    m.rbyte(1'b1, d);
    check(d, e1);
    m.stop();
    check(sdaOe, 0);
  endtask : rd2
  task automatic test_wrap();
    sel = 3'h5;
    open_at(3'h5, 16'hfffe);
    put(8'h11);
    put(8'h22);
    put(8'h33);
    m.stop();
    open_at(3'h5, 16'h3fff);
    rd2(3'h5, 8'h22, 8'h33);
    $display("test wrap done");
  endtask : test_wrap
  task automatic test_select();
    logic k;
    for (int i = 0; i < 8; i++) begin
      @(negedge clock) sel = 3'(i);
      m.start();
      m.wbyte({`TYPE_CODE, 3'(i), 1'b0}, k);
      check(k, 1);
      m.start();
      m.wbyte({`TYPE_CODE, 3'(i) ^ 3'h1, 1'b0}, k);
      check(k, 0);
      m.start();
      m.wbyte({~`TYPE_CODE, 3'(i), 1'b0}, k);
      check(k, 0);
      m.stop();
    end
    $display("test select done");
  endtask : test_select
  task automatic test_protect();
    @(negedge clock) sel = 3'h0;
    open_at(3'h0, 16'h0100);
    put(8'h55);
    put(8'h66);
    put(8'h77);
    put(8'h88);
    m.stop();
    @(negedge clock) writeProtect = 1'b1;
    open_at(3'h0, 16'h0100);
    put(8'haa);
    put(8'hbb);
    m.stop();
    rd2(3'h0, 8'h77, 8'h88);
    open_at(3'h0, 16'h0100);
    rd2(3'h0, 8'h55, 8'h66);
    @(negedge clock) writeProtect = 1'b0;
    $display("test protect done");
  endtask : test_protect
  initial begin
    reset = 1'b1;
    sel = 3'h0;
    writeProtect = 1'b0;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    check(deviceId, {`ID_BYTE0, `ID_BYTE1, `ID_BYTE2});
    check(sdaOe, 0);
    test_wrap();
    test_select();
    test_protect();
    close_out();
  end
endmodule : tb_fram_two_wire_slave
`default_nettype wire
